//--- common/ppfm_cfg.svh
/*
  Sizes, lane layout and reset values for the port pin function multiplexer.
  Assumes inclusion wherever the sizes are needed; the guard keeps it single.
  Holds definitions and nothing else.
*/
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH

// Pin population: ports 3, 4 and 5 carry eight pins each, port 6 carries seven
`define PPFM_NUM_PINS      31
`define PPFM_NUM_LCD_PINS  24
`define PPFM_NUM_ANA_PINS  7
`define PPFM_ANA_BASE      24

// Each pin owns one lane per select code {high,low}
`define PPFM_NUM_SEL       4
`define PPFM_SEL_W         2
`define PPFM_LANES         124

// Reset values of the registered outputs
`define PPFM_RST_PAD       31'h0000_0000
`define PPFM_RST_LCD       24'h00_0000
`define PPFM_RST_LANES     124'h0

`endif

//--- common/ppfm_pkg.sv
/*
  Types shared by the pin function multiplexer and its per-pin cell.
  Assumes the constants header sits beside it on the include path.
*/
package ppfm_pkg;
`include "ppfm_cfg.svh"

  // What a select code means on a given pin
  typedef enum logic [2:0] {
    PPFM_K_GPIO = 3'h0,  // Plain port I/O
    PPFM_K_SER  = 3'h1,  // Serial module owns the direction
    PPFM_K_TIM  = 3'h2,  // Capture input or compare output by direction
    PPFM_K_IN   = 3'h3,  // Peripheral input only, ground when output
    PPFM_K_OUT  = 3'h4,  // Peripheral output only, nothing when input
    PPFM_K_NONE = 3'h5,  // No function, ground when output
    PPFM_K_ANA  = 3'h6   // Analog or LCD bias, digital side cut off
  } ppfm_kind_t;

  // Whole registered state of the top module
  typedef struct packed {
    logic [`PPFM_NUM_PINS-1:0]     sync1;
    logic [`PPFM_NUM_PINS-1:0]     sync2;
    logic [`PPFM_NUM_PINS-1:0]     pad_out;
    logic [`PPFM_NUM_PINS-1:0]     pad_oe;
    logic [`PPFM_NUM_PINS-1:0]     pad_ie;
    logic [`PPFM_NUM_PINS-1:0]     gpio_in;
    logic [`PPFM_NUM_LCD_PINS-1:0] lcd_conn;
    logic [`PPFM_LANES-1:0]        periph_in;
  } ppfm_state_t;

endpackage : ppfm_pkg

//--- tb/ppfm_periph_model.sv
/*
  Stand-in for the serial, timer and clock peripherals on the far side.
  Assumes the bench picks drive and level between clock edges.
*/
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_periph_model
  import ppfm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   ser_drive,
  input  wire logic                   ser_level,
  output logic      [`PPFM_LANES-1:0] periph_out,
  output logic      [`PPFM_LANES-1:0] periph_oe
);
  // Idle lanes show the inverse, so a stale value never passes
  always_ff @(posedge clk) begin
    periph_oe  <= {`PPFM_LANES{ser_drive}};
    periph_out <= {`PPFM_LANES{ser_drive ? ser_level : ~ser_level}};
  end
endmodule : ppfm_periph_model

//--- tb/ppfm_port_mux_monitor.sv
/*
  Port checker for the pin function mux.
  Assumes a bind onto ppfm_port_mux, one clock, sync reset.
*/
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_port_mux_monitor
  import ppfm_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic [`PPFM_NUM_PINS-1:0]     port_direction_bit,
  input wire logic [`PPFM_NUM_LCD_PINS-1:0] function_select_high_bit,
  input wire logic [`PPFM_NUM_LCD_PINS-1:0] function_select_low_bit,
  input wire logic [`PPFM_NUM_ANA_PINS-1:0] analog_select_high_bit,
  input wire logic [`PPFM_NUM_ANA_PINS-1:0] analog_select_low_bit,
  input wire logic [`PPFM_NUM_LCD_PINS-1:0] lcd_segment_enable,
  input wire logic [`PPFM_NUM_PINS-1:0]     gpio_out_level,
  input wire logic [`PPFM_LANES-1:0]        periph_oe,
  input wire logic [`PPFM_NUM_PINS-1:0]     pad_in,
  input wire logic [`PPFM_NUM_PINS-1:0]     pad_out,
  input wire logic [`PPFM_NUM_PINS-1:0]     pad_oe,
  input wire logic [`PPFM_NUM_PINS-1:0]     pad_ie,
  input wire logic [`PPFM_NUM_LCD_PINS-1:0] lcd_connect,
  input wire logic [`PPFM_LANES-1:0]        periph_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pins in plain port use: zero codes, no segment
  logic [`PPFM_NUM_PINS-1:0] gm;
  assign gm = ~{analog_select_high_bit | analog_select_low_bit,
                function_select_high_bit | function_select_low_bit | lcd_segment_enable};
  // Three edges of serial code on P3.5 cover the sync path
  sequence s_ser5_held;
    (!function_select_high_bit[5] && function_select_low_bit[5] && !lcd_segment_enable[5]) [*3];
  endsequence
  a_gpio_dir: assert property (1'b1 |=> ((pad_oe ^ $past(port_direction_bit)) & $past(gm)) == '0)
    else $error("plain pin direction wrong");
  a_gpio_out: assert property (1'b1 |=> ((pad_out ^ $past(gpio_out_level)) & $past(gm & port_direction_bit)) == '0)
    else $error("plain pin level wrong");
  a_lcd_follow: assert property (1'b1 |=> lcd_connect == $past(lcd_segment_enable))
    else $error("segment link wrong");
  a_lcd_no_drive: assert property (1'b1 |=> (pad_oe[23:0] & $past(lcd_segment_enable)) == '0)
    else $error("segment pin still driven");
  a_ana_cut_off: assert property (1'b1 |=> ((pad_oe[30:24] | pad_ie[30:24]) & $past(analog_select_high_bit & analog_select_low_bit)) == '0)
    else $error("bias pin not cut off");
  a_ser_a2_dir: assert property ((!function_select_high_bit[4] && function_select_low_bit[4] && !lcd_segment_enable[4]) |=> pad_oe[4] == $past(periph_oe[17]))
    else $error("serial A second direction wrong");
  a_ser_b2_dir: assert property ((function_select_high_bit[12] && !function_select_low_bit[12] && !lcd_segment_enable[12]) |=> pad_oe[12] == $past(periph_oe[50]))
    else $error("serial B second direction wrong");
  a_ser_a1_alt: assert property ((!function_select_high_bit[10] && function_select_low_bit[10] && !lcd_segment_enable[10]) |=> pad_oe[10] == $past(periph_oe[41]))
    else $error("serial A first direction wrong");
  a_tie_ground: assert property ((function_select_high_bit[0] && port_direction_bit[0] && !lcd_segment_enable[0]) |=> pad_oe[0] && !pad_out[0])
    else $error("unused output not grounded");
  a_ser_in_route: assert property (s_ser5_held |=> periph_in[21] == $past(pad_in[5], 3))
    else $error("serial input lane wrong");
endmodule : ppfm_port_mux_monitor

//--- tb/ppfm_port_mux_test.sv
/*
  Bench for the pin function mux: drives controls and pads on the falling
  edge and compares pad and routing outputs with expected levels.
  Assumes the checker and the peripheral stand-in are compiled first.
*/
`timescale 1ns/1ps
module ppfm_port_mux_test;
  import ppfm_pkg::*;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic [30:0]  dir = '0, gol = '0, pin = '0, po, oe, ie, gi;
  logic [23:0]  hi = '0, lo = '0, lcd = '0, lc;
  logic [6:0]   ahi = '0, alo = '0;
  logic         drv = 1'b0, lvl = 1'b0;
  logic [123:0] pout, poe, pi;
  int           n_errors = 0;
  int           total_checks = 0;
  ppfm_port_mux i_ppfm_port_mux (
    .clk(clk), .sys_rst(sys_rst), .port_direction_bit(dir), .function_select_high_bit(hi),
    .function_select_low_bit(lo), .analog_select_high_bit(ahi), .analog_select_low_bit(alo),
    .lcd_segment_enable(lcd), .gpio_out_level(gol), .periph_out(pout), .periph_oe(poe),
    .pad_in(pin), .pad_out(po), .pad_oe(oe), .pad_ie(ie), .lcd_connect(lc), .gpio_in(gi),
    .periph_in(pi));
  ppfm_periph_model i_ppfm_periph_model (
    .clk(clk), .ser_drive(drv), .ser_level(lvl), .periph_out(pout), .periph_oe(poe));
  initial begin
    forever #50 clk = ~clk;
  end
  // One compare, counted; widest value is a lane vector
  task automatic check(input logic [123:0] seen, input logic [123:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Outputs are levels; three edges cover the sync path too
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    tick(2);
    check(124'({oe, lc, ie}), '0);
    check(pi, '0);
    sys_rst = 1'b0;
    $display("test reset done");
    dir = '1; gol = 31'h2aaa_aaaa; pin = 31'h1555_5555; tick(3);
    check(124'(oe), 124'(31'h7fff_ffff));
    check(124'(po), 124'(gol));
    check(124'(gi), 124'(pin));
    dir = '0; tick(3);
    check(124'(oe), '0);
    $display("test gpio done");
    lo = 24'h0434; hi = 24'h1000; drv = 1'b1; lvl = 1'b1; pin = 31'h20; tick(3);
    check(124'(oe & 31'h1414), 124'(31'h1414));
    check(124'(po & 31'h1414), 124'(31'h1414));
    check(pi, 124'h1 << 21);
    dir = '1; drv = 1'b0; tick(3);
    check(124'(oe & 31'h1414), '0);
    $display("test serial done");
    hi = 24'h1; lo = 24'h8; drv = 1'b1; gol = '1; tick(3);
    check(124'({oe[3], oe[0], po[3], po[0]}), 124'h0c);
    $display("test ground done");
    // bias code cuts driver and trigger
    ahi = '1; alo = '1; pin = '1; tick(3);
    check(124'({oe[30:24], ie[30:24], gi[30:24]}), '0);
    $display("test analog done");
    // timer, clock-in and clock-out codes by direction
    hi = 24'h118; lo = 24'h108; gol = '0; tick(3);
    check(124'({oe[8], oe[4], oe[3], po[8], po[4], po[3]}), 124'h3e);
    dir = '0; tick(3);
    check(124'(oe), '0);
    check(pi, 124'h4_8000);
    $display("test timer done");
    lcd = '1;
    for (int s = 0; s < 4; s++) begin
      hi = {24{s[1]}}; lo = {24{s[0]}}; tick(3);
      check(124'({lc, oe[23:0], ie[23:0]}), 124'({24'hff_ffff, 48'h0}));
    end
    lcd = '0; tick(3);
    check(124'(lc), '0);
    $display("test segment done");
    results();
  end
endmodule : ppfm_port_mux_test
bind ppfm_port_mux ppfm_port_mux_monitor i_ppfm_port_mux_monitor (
  .clk(clk), .sys_rst(sys_rst), .port_direction_bit(port_direction_bit),
  .function_select_high_bit(function_select_high_bit), .function_select_low_bit(function_select_low_bit),
  .analog_select_high_bit(analog_select_high_bit), .analog_select_low_bit(analog_select_low_bit),
  .lcd_segment_enable(lcd_segment_enable), .gpio_out_level(gpio_out_level), .periph_oe(periph_oe),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie), .lcd_connect(lcd_connect),
  .periph_in(periph_in));

//--- verilog/ppfm_pin_cell.sv
/*
  Combinational function cell for one pin: turns the decoded function kind,
  direction and segment enable into pad drive, input enable and routing.
  Assumes a synchronised pad level and registers placed around it by the top.
*/
`timescale 1ns/1ps
module ppfm_pin_cell
  import ppfm_pkg::*;
(
  input  wire ppfm_kind_t kind,
  input  wire logic       dir,
  input  wire logic       lcd_en,
  input  wire logic       gpio_out,
  input  wire logic       periph_out,
  input  wire logic       periph_oe,
  input  wire logic       pad_level,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pad_ie,
  output logic            lcd_conn,
  output logic            gpio_in,
  output logic            periph_in
);

  // Function decode; the segment enable overrides every other control
  always_comb begin
    pad_out   = 1'b0;
    pad_oe    = 1'b0;
    pad_ie    = 1'b1;
    lcd_conn  = 1'b0;
    periph_in = 1'b0;
    if (lcd_en) begin
      lcd_conn = 1'b1;
      pad_ie   = 1'b0;  // Keeps the segment waveform out of the digital input
    end else begin
      case (kind)
        PPFM_K_GPIO: begin
          pad_oe  = dir;
          pad_out = gpio_out;
        end
        PPFM_K_SER: begin
          pad_oe    = periph_oe;
          pad_out   = periph_out;
          periph_in = pad_level;
        end
        PPFM_K_TIM: begin
          if (dir) begin
            pad_oe  = 1'b1;
            pad_out = periph_out;
          end else begin
            periph_in = pad_level;
          end
        end
        PPFM_K_IN: begin
          if (dir) begin
            pad_oe  = 1'b1;
            pad_out = 1'b0;
          end else begin
            periph_in = pad_level;
          end
        end
        PPFM_K_OUT: begin
          pad_oe  = dir;
          pad_out = dir & periph_out;
        end
        PPFM_K_NONE: begin
          pad_oe  = dir;
          pad_out = 1'b0;
        end
        PPFM_K_ANA: begin
          pad_oe = 1'b0;
          pad_ie = 1'b0;
        end
        default: begin
          pad_oe = 1'b0;
        end
      endcase
    end
  end

  // Port input reads the pad only while the input buffer is on
  assign gpio_in = pad_level & pad_ie;

endmodule : ppfm_pin_cell

//--- verilog/ppfm_port_mux.sv
/*
  Pin function multiplexer for ports 3 to 6: per pin, the direction bit,
  the two select bits and the segment enable pick GPIO, serial, timer,
  clock, segment or analog use, and the result is registered toward the pad.
  Assumes control bits and peripheral signals come from logic on clk, and
  that pad_in arrives from the pin, asynchronous to clk.
*/
// Notes on behaviour
// - Direction, selects, segment enable choose function.
// - Second A serial sets its pin direction.
// - Second B serial sets its pin direction.
// - Alternate first A serial routing sets direction.
// - Missing peripheral output drives ground.
// - Port 6 analog code cuts driver, trigger.
// - Segment enable connects LCD segment always.
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_port_mux
  import ppfm_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic [`PPFM_NUM_PINS-1:0]      port_direction_bit,
  input  wire logic [`PPFM_NUM_LCD_PINS-1:0]  function_select_high_bit,
  input  wire logic [`PPFM_NUM_LCD_PINS-1:0]  function_select_low_bit,
  input  wire logic [`PPFM_NUM_ANA_PINS-1:0]  analog_select_high_bit,
  input  wire logic [`PPFM_NUM_ANA_PINS-1:0]  analog_select_low_bit,
  input  wire logic [`PPFM_NUM_LCD_PINS-1:0]  lcd_segment_enable,
  input  wire logic [`PPFM_NUM_PINS-1:0]      gpio_out_level,
  input  wire logic [`PPFM_LANES-1:0]         periph_out,
  input  wire logic [`PPFM_LANES-1:0]         periph_oe,
  input  wire logic [`PPFM_NUM_PINS-1:0]      pad_in,
  output logic      [`PPFM_NUM_PINS-1:0]      pad_out,
  output logic      [`PPFM_NUM_PINS-1:0]      pad_oe,
  output logic      [`PPFM_NUM_PINS-1:0]      pad_ie,
  output logic      [`PPFM_NUM_LCD_PINS-1:0]  lcd_connect,
  output logic      [`PPFM_NUM_PINS-1:0]      gpio_in,
  output logic      [`PPFM_LANES-1:0]         periph_in
);

  // Function kind per pin and select code, index [pin][{high,low}].
  // Code 0 is always plain I/O. Pin order: P3.0..P3.7, P4.0..P4.7,
  // P5.0..P5.7, P6.0..P6.6.
  localparam ppfm_kind_t KIND_TAB [`PPFM_NUM_PINS][`PPFM_NUM_SEL] = '{
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_NONE},  // P3.0 B clock
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_NONE},  // P3.1 B data/bus
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_NONE},  // P3.2 B data/bus
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_TIM,  PPFM_K_IN},    // P3.3 timer, clock in
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_TIM,  PPFM_K_NONE},  // P3.4 A transmit
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_TIM,  PPFM_K_NONE},  // P3.5 A receive
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_TIM,  PPFM_K_NONE},  // P3.6 A clock
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_TIM,  PPFM_K_NONE},  // P3.7 A select
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_OUT},   // P4.0 B data, main clock
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_OUT},   // P4.1 B data, aux clock
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_SER,  PPFM_K_NONE},  // P4.2 first A alt, B clock
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_SER,  PPFM_K_NONE},  // P4.3 first A alt, B select
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_IN},    // P4.4 B select, timer clock
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_TIM},   // P4.5 B clock, timer
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_TIM},   // P4.6 B data, timer
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_TIM},   // P4.7 B data, timer
    '{PPFM_K_GPIO, PPFM_K_TIM,  PPFM_K_NONE, PPFM_K_OUT},   // P5.0 timer, main clock
    '{PPFM_K_GPIO, PPFM_K_TIM,  PPFM_K_NONE, PPFM_K_NONE},  // P5.1 timer
    '{PPFM_K_GPIO, PPFM_K_TIM,  PPFM_K_IN,   PPFM_K_OUT},   // P5.2 timer, clock in, aux
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_SER,  PPFM_K_NONE},  // P5.3 B select
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_NONE},  // P5.4 A transmit
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_NONE},  // P5.5 A receive
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_NONE},  // P5.6 A clock
    '{PPFM_K_GPIO, PPFM_K_SER,  PPFM_K_NONE, PPFM_K_IN},    // P5.7 A select, clock in
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_NONE, PPFM_K_ANA},   // P6.0 bias
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_NONE, PPFM_K_ANA},   // P6.1 bias, reference
    '{PPFM_K_GPIO, PPFM_K_OUT,  PPFM_K_NONE, PPFM_K_ANA},   // P6.2 comparator out, bias
    '{PPFM_K_GPIO, PPFM_K_NONE, PPFM_K_NONE, PPFM_K_ANA},   // P6.3 common
    '{PPFM_K_GPIO, PPFM_K_TIM,  PPFM_K_NONE, PPFM_K_ANA},   // P6.4 timer, common
    '{PPFM_K_GPIO, PPFM_K_TIM,  PPFM_K_NONE, PPFM_K_ANA},   // P6.5 timer, common
    '{PPFM_K_GPIO, PPFM_K_TIM,  PPFM_K_NONE, PPFM_K_ANA}    // P6.6 timer, common
  };

  ppfm_state_t state_reg;
  ppfm_state_t state_next;

  // Combinational results of the per-pin cells
  logic [`PPFM_NUM_PINS-1:0]     cell_pad_out;
  logic [`PPFM_NUM_PINS-1:0]     cell_pad_oe;
  logic [`PPFM_NUM_PINS-1:0]     cell_pad_ie;
  logic [`PPFM_NUM_PINS-1:0]     cell_lcd;
  logic [`PPFM_NUM_PINS-1:0]     cell_gpio_in;
  logic [`PPFM_LANES-1:0]        cell_periph_in;

  // Joined select and segment vectors, so every pin decodes the same way
  logic [`PPFM_NUM_PINS-1:0]     sel_high;
  logic [`PPFM_NUM_PINS-1:0]     sel_low;
  logic [`PPFM_NUM_PINS-1:0]     seg_en;

  assign sel_high = {analog_select_high_bit, function_select_high_bit};
  assign sel_low  = {analog_select_low_bit, function_select_low_bit};
  // Port 6 pins have no segment; their enable is held low
  assign seg_en   = {{`PPFM_NUM_ANA_PINS{1'b0}}, lcd_segment_enable};

  // One cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < `PPFM_NUM_PINS; gi++) begin : g_pin
      logic [`PPFM_SEL_W-1:0]  sel;
      logic [`PPFM_NUM_SEL-1:0] lane_out;
      logic [`PPFM_NUM_SEL-1:0] lane_oe;
      logic [`PPFM_NUM_SEL-1:0] lane_in;
      ppfm_kind_t               kind;
      logic                     cell_in;  // Pad level the cell routes inward

      assign sel      = {sel_high[gi], sel_low[gi]};
      assign kind     = KIND_TAB[gi][sel];
      assign lane_out = periph_out[gi*`PPFM_NUM_SEL +: `PPFM_NUM_SEL];
      assign lane_oe  = periph_oe[gi*`PPFM_NUM_SEL +: `PPFM_NUM_SEL];

      ppfm_pin_cell u_cell (
        .kind       (kind),
        .dir        (port_direction_bit[gi]),
        .lcd_en     (seg_en[gi]),
        .gpio_out   (gpio_out_level[gi]),
        .periph_out (lane_out[sel]),
        .periph_oe  (lane_oe[sel]),
        .pad_level  (state_reg.sync2[gi]),
        .pad_out    (cell_pad_out[gi]),
        .pad_oe     (cell_pad_oe[gi]),
        .pad_ie     (cell_pad_ie[gi]),
        .lcd_conn   (cell_lcd[gi]),
        .gpio_in    (cell_gpio_in[gi]),
        .periph_in  (cell_in)
      );

      // Only the selected lane sees the pad; the others read low
      always_comb begin
        lane_in = '0;
        lane_in[sel] = cell_in;
      end
      assign cell_periph_in[gi*`PPFM_NUM_SEL +: `PPFM_NUM_SEL] = lane_in;
    end
  endgenerate

  // Next state: pad synchroniser plus registered cell results
  always_comb begin
    state_next           = state_reg;
    state_next.sync1     = pad_in;
    state_next.sync2     = state_reg.sync1;
    state_next.pad_out   = cell_pad_out;
    state_next.pad_oe    = cell_pad_oe;
    state_next.pad_ie    = cell_pad_ie;
    state_next.gpio_in   = cell_gpio_in;
    state_next.lcd_conn  = cell_lcd[`PPFM_NUM_LCD_PINS-1:0];
    state_next.periph_in = cell_periph_in;
  end

  // Synchronous reset leaves every driver off and every route quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.sync1     <= `PPFM_RST_PAD;
      state_reg.sync2     <= `PPFM_RST_PAD;
      state_reg.pad_out   <= `PPFM_RST_PAD;
      state_reg.pad_oe    <= `PPFM_RST_PAD;
      state_reg.pad_ie    <= `PPFM_RST_PAD;
      state_reg.gpio_in   <= `PPFM_RST_PAD;
      state_reg.lcd_conn  <= `PPFM_RST_LCD;
      state_reg.periph_in <= `PPFM_RST_LANES;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pad_out     = state_reg.pad_out;
  assign pad_oe      = state_reg.pad_oe;
  assign pad_ie      = state_reg.pad_ie;
  assign lcd_connect = state_reg.lcd_conn;
  assign gpio_in     = state_reg.gpio_in;
  assign periph_in   = state_reg.periph_in;

endmodule : ppfm_port_mux
